// >>> design/bcox_pkg.sv
// Package of the baseline core operation block: offsets, fields, resets,
// opcode patterns, operation kinds and carrier structs.
// Assumes a 32-bit APB slave port with 8-bit byte addresses.
package bcox_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_ACC = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_PC = 8'h0c;
	localparam logic [7:0] OFF_INFO = 8'h10;
	localparam logic [7:0] OFF_CYCLES = 8'h14;
	localparam logic [7:0] OFF_FILE_BASE = 8'h80;

	// Field positions
	localparam int unsigned STATUS_Z_BIT = 2;
	localparam int unsigned STATUS_PAGE_LO = 5;
	localparam int unsigned STATUS_PAGE_HI = 6;
	localparam int unsigned INFO_FLUSH_BIT = 0;
	localparam int unsigned INFO_ILLEGAL_BIT = 1;
	localparam int unsigned FILE_SEL_BIT = 7;

	// Widths
	localparam int unsigned IW = 12;
	localparam int unsigned PCW = 11;
	localparam int unsigned FILE_DEPTH = 32;

	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [7:0] FILE_RST = 8'h00;
	localparam logic [31:0] CYCLES_RST = 32'h0000_0000;

	// Opcode patterns, matched from the top of the instruction word
	localparam logic [11:0] OPC_IDLE = 12'h000;
	localparam logic [6:0] OPC_STORE = 7'h01;
	localparam logic [5:0] OPC_OR_FILE = 6'h04;
	localparam logic [5:0] OPC_MOVE = 6'h08;
	localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
	localparam logic [2:0] OPC_JUMP = 3'h5;
	localparam logic [3:0] OPC_LOAD_LIT = 4'hc;
	localparam logic [3:0] OPC_OR_LIT = 4'hd;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_INC_SKIP,
		OP_JUMP,
		OP_OR_LIT,
		OP_OR_FILE,
		OP_STORE,
		OP_MOVE,
		OP_LOAD_LIT
	} bcox_op_t;

	typedef struct packed {
		bcox_op_t op;
		logic illegal;
		logic [4:0] f;
		logic dest;
		logic [7:0] k8;
		logic [8:0] k9;
	} bcox_instr_t;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bcox_apb_req_t;

endpackage : bcox_pkg

// >>> design/bcox_decode.sv
// Instruction decoder: splits a 12-bit word into operation and operands.
// Purely combinational; unknown words decode as idle with illegal set.
`timescale 1ns/1ps
module bcox_decode
	import bcox_pkg::*;
(
	input wire logic [11:0] word,
	output bcox_instr_t instr
);

	always_comb
	begin
		instr.op = OP_IDLE;
		instr.illegal = 1'b0;
		instr.f = word[4:0];
		instr.dest = word[5];
		instr.k8 = word[7:0];
		instr.k9 = word[8:0];
		if (word == OPC_IDLE)
			instr.op = OP_IDLE;
		else if (word[11:5] == OPC_STORE)
			instr.op = OP_STORE;
		else if (word[11:6] == OPC_OR_FILE)
			instr.op = OP_OR_FILE;
		else if (word[11:6] == OPC_MOVE)
			instr.op = OP_MOVE;
		else if (word[11:6] == OPC_INC_SKIP)
			instr.op = OP_INC_SKIP;
		else if (word[11:9] == OPC_JUMP)
			instr.op = OP_JUMP;
		else if (word[11:8] == OPC_LOAD_LIT)
			instr.op = OP_LOAD_LIT;
		else if (word[11:8] == OPC_OR_LIT)
			instr.op = OP_OR_LIT;
		else
			instr.illegal = 1'b1;
	end

endmodule : bcox_decode

// >>> design/bcox_file_regs.sv
// File register array: 32 entries of 8 bits, one write, two read ports.
// Assumes the caller never needs two writes in one cycle.
`timescale 1ns/1ps
module bcox_file_regs
	import bcox_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic [4:0] rd_idx_a,
	output logic [7:0] rd_data_a,
	input wire logic [4:0] rd_idx_b,
	output logic [7:0] rd_data_b
);

	logic [7:0] mem [FILE_DEPTH];

	genvar i;
	generate
		for (i = 0; i < FILE_DEPTH; i++)
		begin : g_entry
			logic [7:0] next_mem;
			always_comb
			begin
				next_mem = mem[i];
				if (wr_en && wr_idx == 5'(i))
					next_mem = wr_data;
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mem[i] <= FILE_RST;
				else
					mem[i] <= next_mem;
			end
		end
	endgenerate

	assign rd_data_a = mem[rd_idx_a];
	assign rd_data_b = mem[rd_idx_b];

endmodule : bcox_file_regs

// >>> design/bcox_core.sv
// Baseline core operation block: executes issued instruction words against
// accumulator, status, program counter and file registers over APB.
// Assumes one clock, synchronous APB inputs, software issuing one word
// per write to the instruction register.
//
// Operation
// - Increment-skip adds one to file f; result to acc or file; flags kept.
// - Zero increment result discards next fetched word, runs idle instead.
// - Jump loads the 9-bit literal into program counter bits 8:0.
// - Jump loads program counter bits 10:9 from status bits 6:5.
// - Jump takes two cycles, flushing the word fetched after it.
// - Or-literal ORs acc with 8-bit literal into acc, updates zero.
// - Or-file ORs acc with file f into acc or file, updates zero.
// - Store copies acc into file f, leaving all flags unchanged.
// - Move-file copies file f to acc or back to file f.
// - Move-file updates zero even when written back to the same file.
// - Load-literal puts the 8-bit literal into acc, flags unchanged.
`timescale 1ns/1ps
module bcox_core
	import bcox_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_SKIP,
		ST_FILL
	} bcox_state_t;

	bcox_apb_req_t req;
	bcox_instr_t dec;
	bcox_state_t state;
	bcox_state_t next_state;

	logic [7:0] acc;
	logic [7:0] next_acc;
	logic [7:0] status;
	logic [7:0] next_status;
	logic [10:0] pc;
	logic [10:0] next_pc;
	logic [31:0] cycles;
	logic [31:0] next_cycles;
	logic illegal;
	logic next_illegal;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	logic access;
	logic take;
	logic is_file;
	logic mapped;
	logic exec;
	logic flushing;
	logic [7:0] file_a;
	logic [7:0] file_b;
	logic [7:0] inc_val;
	logic [7:0] or_file_val;
	logic [7:0] or_lit_val;
	logic wr_en;
	logic [4:0] wr_idx;
	logic [7:0] wr_data;
	logic [31:0] rd_mux;

	assign req = '{sel: psel, enable: penable, write: pwrite,
		addr: paddr, wdata: pwdata};

	bcox_decode u_decode (
		.word(req.wdata[11:0]),
		.instr(dec)
	);

	bcox_file_regs u_file (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.rd_idx_a(dec.f),
		.rd_data_a(file_a),
		.rd_idx_b(req.addr[6:2]),
		.rd_data_b(file_b)
	);

	// Bus decode; a transfer is taken at the edge where pready is high
	assign access = req.sel && req.enable;
	assign take = access && pready;
	assign is_file = req.addr[FILE_SEL_BIT];
	assign mapped = (req.addr[1:0] == 2'b00) && (is_file
		|| req.addr == OFF_INSTR || req.addr == OFF_ACC
		|| req.addr == OFF_STATUS || req.addr == OFF_PC
		|| req.addr == OFF_INFO || req.addr == OFF_CYCLES);
	assign exec = take && req.write && req.addr == OFF_INSTR;
	assign flushing = state != ST_RUN;

	// Datapath results
	assign inc_val = 8'(file_a + 8'h01);
	assign or_file_val = acc | file_a;
	assign or_lit_val = acc | dec.k8;

	// Read mux
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (is_file)
			rd_mux = {24'h00_0000, file_b};
		else
		begin
			case (req.addr)
				OFF_ACC: rd_mux = {24'h00_0000, acc};
				OFF_STATUS: rd_mux = {24'h00_0000, status};
				OFF_PC: rd_mux = {21'h0, pc};
				OFF_INFO: rd_mux = {30'h0, illegal, flushing};
				OFF_CYCLES: rd_mux = cycles;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// APB answer: one wait state, then pready with data and error
	always_comb
	begin
		next_pready = access && !pready;
		next_pslverr = access && !pready && !mapped;
		next_prdata = prdata;
		if (access && !pready && !req.write)
			next_prdata = mapped ? rd_mux : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// Execution and software writes
	always_comb
	begin
		next_state = state;
		next_acc = acc;
		next_status = status;
		next_pc = pc;
		next_cycles = cycles;
		next_illegal = illegal;
		wr_en = 1'b0;
		wr_idx = dec.f;
		wr_data = 8'h00;
		if (exec)
		begin
			next_cycles = 32'(cycles + 32'h0000_0001);
			if (state == ST_SKIP)
			begin
				// Discarded word runs as idle; its slot is passed over
				next_state = ST_RUN;
				next_pc = 11'(pc + 11'h001);
			end
			else if (state == ST_FILL)
			begin
				// Second cycle of the jump; target already in pc
				next_state = ST_RUN;
			end
			else
			begin
				next_pc = 11'(pc + 11'h001);
				next_illegal = illegal || dec.illegal;
				case (dec.op)
					OP_IDLE:
					begin
						next_pc = 11'(pc + 11'h001);
					end
					OP_INC_SKIP:
					begin
						if (dec.dest)
						begin
							wr_en = 1'b1;
							wr_data = inc_val;
						end
						else
							next_acc = inc_val;
						if (inc_val == 8'h00)
							next_state = ST_SKIP;
					end
					OP_JUMP:
					begin
						next_pc = {status[STATUS_PAGE_HI:STATUS_PAGE_LO],
							dec.k9};
						next_state = ST_FILL;
					end
					OP_OR_LIT:
					begin
						next_acc = or_lit_val;
						next_status[STATUS_Z_BIT] = or_lit_val == 8'h00;
					end
					OP_OR_FILE:
					begin
						if (dec.dest)
						begin
							wr_en = 1'b1;
							wr_data = or_file_val;
						end
						else
							next_acc = or_file_val;
						next_status[STATUS_Z_BIT] = or_file_val == 8'h00;
					end
					OP_STORE:
					begin
						wr_en = 1'b1;
						wr_data = acc;
					end
					OP_MOVE:
					begin
						if (dec.dest)
						begin
							wr_en = 1'b1;
							wr_data = file_a;
						end
						else
							next_acc = file_a;
						next_status[STATUS_Z_BIT] = file_a == 8'h00;
					end
					OP_LOAD_LIT:
					begin
						// Upper literal bits expected zero from the encoder
						next_acc = dec.k8;
					end
					default:
					begin
						next_pc = 11'(pc + 11'h001);
					end
				endcase
			end
		end
		else if (take && req.write)
		begin
			if (is_file)
			begin
				wr_en = 1'b1;
				wr_idx = req.addr[6:2];
				wr_data = req.wdata[7:0];
			end
			else
			begin
				case (req.addr)
					OFF_ACC: next_acc = req.wdata[7:0];
					OFF_STATUS: next_status = req.wdata[7:0];
					OFF_PC: next_pc = req.wdata[10:0];
					OFF_INFO:
					begin
						// Write one clears the sticky illegal flag
						if (req.wdata[INFO_ILLEGAL_BIT])
							next_illegal = 1'b0;
					end
					default:
					begin
						next_acc = acc;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_RUN;
			acc <= ACC_RST;
			status <= STATUS_RST;
			pc <= PC_RST;
			cycles <= CYCLES_RST;
			illegal <= 1'b0;
		end
		else
		begin
			state <= next_state;
			acc <= next_acc;
			status <= next_status;
			pc <= next_pc;
			cycles <= next_cycles;
			illegal <= next_illegal;
		end
	end

endmodule : bcox_core

// >>> dv/bcox_core_chk.sv
// Checker for the core block, watching only its APB ports.
// Assumes a single clock domain with active-low asynchronous reset.
`timescale 1ns/1ps
module bcox_core_chk
	import bcox_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_req: assert property (pready |-> psel && penable)
		else $error("pready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	a_instr_ok: assert property (
		pready && pwrite && paddr == OFF_INSTR |-> !pslverr)
		else $error("instruction write refused");
	a_unmapped_zero: assert property (pready && pslverr && !pwrite |->
		prdata == 32'h0) else $error("refused read not zero");
	a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
		else $error("read data moved outside a read");

	cover property (pready && pwrite && paddr == OFF_INSTR);
	cover property (pready && pslverr);
	cover property (pready && !pwrite && paddr >= OFF_FILE_BASE);
endmodule : bcox_core_chk

bind bcox_core bcox_core_chk i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> dv/bcox_core_bench.sv
// Self-checking bench: issues words and checks registers over APB.
// Assumes the register map and encodings of the core's package.
`timescale 1ns/1ps
module bcox_core_bench;
	import bcox_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	int num_errors = 0;
	int check_count = 0;

	always #2.5 pclk = ~pclk;

	bcox_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1 && ++n < 20);
		if (n >= 20)
			num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(rd, e);
	endtask : rc

	task automatic ex(input logic [11:0] w);
		xfer(1'h1, OFF_INSTR, {20'h0, w});
	endtask : ex

	function automatic logic [7:0] fa(input int i);
		return OFF_FILE_BASE + 8'(i * 4);
	endfunction : fa

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#50000;
		num_errors++;
		report_and_stop();
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rc(OFF_ACC, 32'h0);
		rc(OFF_PC, 32'h0);
		$display("reset test done");
		ex(12'hd00);
		rc(OFF_STATUS, 32'h4);
		ex(12'hca5);
		rc(OFF_ACC, 32'ha5);
		rc(OFF_STATUS, 32'h4);
		ex(12'hd5a);
		rc(OFF_ACC, 32'hff);
		rc(OFF_STATUS, 32'h0);
		$display("literal test done");
		xfer(1'h1, fa(3), 32'h0);
		ex(12'h223);
		rc(OFF_STATUS, 32'h4);
		ex(12'h03f);
		rc(fa(31), 32'hff);
		rc(OFF_STATUS, 32'h4);
		ex(12'hc30);
		xfer(1'h1, fa(2), 32'h5);
		ex(12'h122);
		rc(fa(2), 32'h35);
		rc(OFF_STATUS, 32'h0);
		ex(12'h21f);
		rc(OFF_ACC, 32'hff);
		$display("file test done");
		xfer(1'h1, OFF_PC, 32'h0);
		xfer(1'h1, fa(5), 32'hff);
		ex(12'h3e5);
		ex(12'hc11);
		rc(fa(5), 32'h0);
		rc(OFF_ACC, 32'hff);
		rc(OFF_PC, 32'h2);
		rc(OFF_STATUS, 32'h0);
		xfer(1'h1, fa(6), 32'h10);
		ex(12'h3c6);
		rc(OFF_ACC, 32'h11);
		ex(12'hc22);
		rc(OFF_ACC, 32'h22);
		$display("skip test done");
		xfer(1'h1, OFF_STATUS, 32'h60);
		ex(12'hb55);
		rc(OFF_INFO, 32'h1);
		ex(12'hc77);
		rc(OFF_PC, 32'h755);
		rc(OFF_ACC, 32'h22);
		rc(OFF_STATUS, 32'h60);
		ex(12'h000);
		rc(OFF_PC, 32'h756);
		rc(OFF_ACC, 32'h22);
		$display("jump test done");
		ex(12'h001);
		rc(OFF_INFO, 32'h2);
		rc(OFF_PC, 32'h757);
		xfer(1'h1, OFF_INFO, 32'h2);
		rc(OFF_INFO, 32'h0);
		rc(OFF_CYCLES, 32'h10);
		$display("illegal and count test done");
		rc(8'h18, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'h1, 8'h05, 32'h1);
		chk({31'h0, err}, 32'h1);
		$display("refusal test done");
		report_and_stop();
	end
endmodule : bcox_core_bench
